// ### logic/exb_pkg.sv
package exb_pkg;
  // configuration byte offsets
  localparam logic [7:0] OFS_R2_MASK   = 8'h74;
  localparam logic [7:0] OFS_TIMING    = 8'h76;
  localparam logic [7:0] OFS_WIDTH     = 8'h78;
  // reset values
  localparam logic [15:0] RST_R2_MASK  = 16'h0000;
  localparam logic [15:0] RST_TIMING   = 16'h0000;
  localparam logic [3:0]  RST_WIDTH    = 4'h0;
  // field positions
  localparam int R2_MASK_LSB           = 1;
  localparam int TIM_FIELD_W           = 4;
  localparam int WID_BITS              = 4;
  // command clocks per code, 16-bit then 8-bit
  localparam logic [4:0] CMD16_C0      = 5'd8;
  localparam logic [4:0] CMD16_C1      = 5'd6;
  localparam logic [4:0] CMD16_C2      = 5'd4;
  localparam logic [4:0] CMD8_C0       = 5'd20;
  localparam logic [4:0] CMD8_C1       = 5'd16;
  localparam logic [4:0] CMD8_C2       = 5'd8;
  localparam logic [4:0] CMD8_C3       = 5'd4;
  // recovery clocks per code
  localparam logic [4:0] REC_C0        = 5'd10;
  localparam logic [4:0] REC_C1        = 5'd8;
  localparam logic [4:0] REC_C2        = 5'd6;
  localparam logic [4:0] REC_C3        = 5'd4;
  // ready is looked at this many clocks before the command ends
  localparam logic [4:0] RDY_LEAD      = 5'd2;
  // fixed dma shape
  localparam logic [4:0] DMA_CMD_CLKS  = 5'd8;
  localparam logic [4:0] DMA_REC_CLKS  = 5'd4;
  typedef enum logic [1:0] {
    REG_R0 = 2'd0, REG_R1 = 2'd1, REG_R2 = 2'd2, REG_OTHER = 2'd3
  } exb_region_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_CMD = 2'b01, ST_REC = 2'b11
  } exb_state_t;
endpackage

// ### logic/exb_region_timing.sv
module exb_region_timing
  import exb_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        RESET,
  input  wire logic        CFG_WR,
  input  wire logic        CFG_RD,
  input  wire logic [7:0]  CFG_ADDR,
  input  wire logic [1:0]  CFG_BE,
  input  wire logic [15:0] CFG_WDATA,
  output logic      [15:0] CFG_RDATA,
  input  wire logic        CYC_START,
  input  wire logic [15:0] CYC_ADDR,
  input  wire logic [15:0] REGION2_BASE,
  input  wire logic        REGION0_HIT,
  input  wire logic        REGION1_HIT,
  input  wire logic        CYC_IS_DMA,
  input  wire logic        IO_WIDE_CLAIM_N,
  input  wire logic        MEM_WIDE_CLAIM_N,
  input  wire logic        EXPANSION_IO_READY,
  output logic             REGION2_HIT,
  output logic             CYC_BUSY,
  output logic             CMD_ACTIVE,
  output logic             CYC_WIDE,
  output exb_pkg::exb_region_t CYC_REGION,
  output logic             CYC_DONE
);
  import exb_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] mask_q;
  logic [15:0] tim_q;
  logic [3:0]  wid_q;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                        input logic [1:0] be);
    merge = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
  endfunction

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      mask_q <= RST_R2_MASK;
      tim_q  <= RST_TIMING;
      wid_q  <= RST_WIDTH;
    end else if (CFG_WR) begin
      case (CFG_ADDR)
        OFS_R2_MASK: mask_q <= merge(mask_q, CFG_WDATA, CFG_BE) & 16'hFFFE;
        OFS_TIMING:  tim_q  <= merge(tim_q, CFG_WDATA, CFG_BE);
        OFS_WIDTH:   if (CFG_BE[0]) wid_q <= CFG_WDATA[WID_BITS-1:0];
        default:     ;
      endcase
    end
  end

  // unmapped and reserved bits read as zero
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      CFG_RDATA <= 16'h0000;
    end else if (CFG_RD) begin
      case (CFG_ADDR)
        OFS_R2_MASK: CFG_RDATA <= mask_q;
        OFS_TIMING:  CFG_RDATA <= tim_q;
        OFS_WIDTH:   CFG_RDATA <= {12'h000, wid_q};
        default:     CFG_RDATA <= 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, first stage read only by the second
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      pin_s1_q <= 3'b110;
      pin_s2_q <= 3'b110;
    end else begin
      pin_s1_q <= {IO_WIDE_CLAIM_N, MEM_WIDE_CLAIM_N, EXPANSION_IO_READY};
      pin_s2_q <= pin_s1_q;
    end
  end
  logic io_claim;
  logic mem_claim;
  logic rdy;
  assign io_claim  = ~pin_s2_q[2];
  assign mem_claim = ~pin_s2_q[1];
  assign rdy       = pin_s2_q[0];

  ////////////////////////////////////////////////////////////////////////////
  // region 2 window decode, base held elsewhere
  assign REGION2_HIT = &((CYC_ADDR[15:R2_MASK_LSB] ~^ REGION2_BASE[15:R2_MASK_LSB])
                         | mask_q[15:R2_MASK_LSB]);

  exb_region_t sel;
  always_comb begin
    if (REGION0_HIT)      sel = REG_R0;
    else if (REGION1_HIT) sel = REG_R1;
    else if (REGION2_HIT) sel = REG_R2;
    else                  sel = REG_OTHER;
  end

  // claims widen a narrow setting; memory claim only counts for other accesses
  logic wide_d;
  assign wide_d = wid_q[sel] | io_claim
                  | ((sel == REG_OTHER) & mem_claim);

  logic [1:0] cmd_code;
  logic [1:0] rec_code;
  assign cmd_code = tim_q[TIM_FIELD_W*sel +: 2];
  assign rec_code = tim_q[TIM_FIELD_W*sel + 2 +: 2];

  logic [4:0] lut_cmd;
  logic [4:0] lut_rec;
  exb_timing_lut u_lut (
    .cmd_code (cmd_code),
    .rec_code (rec_code),
    .wide     (wide_d),
    .cmd_clks (lut_cmd),
    .rec_clks (lut_rec)
  );

  ////////////////////////////////////////////////////////////////////////////
  exb_state_t st_q;
  logic [4:0] cnt_q;
  logic [4:0] rec_q;
  logic       start;
  assign start = (st_q == ST_IDLE) & CYC_START;

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      st_q       <= ST_IDLE;
      cnt_q      <= 5'd0;
      rec_q      <= 5'd0;
      CYC_WIDE   <= 1'b0;
      CYC_REGION <= REG_R0;
      CYC_DONE   <= 1'b0;
    end else begin
      CYC_DONE <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (CYC_START) begin
            st_q       <= ST_CMD;
            CYC_WIDE   <= wide_d;
            CYC_REGION <= sel;
            // dma ignores the programmed timing fields; CYC_WIDE still follows the width register and claims
            cnt_q <= (CYC_IS_DMA ? DMA_CMD_CLKS : lut_cmd) - 5'd1;
            rec_q <= CYC_IS_DMA ? DMA_REC_CLKS : lut_rec;
          end
        end
        ST_CMD: begin
          // hold the count at the sample point until ready returns
          if (cnt_q == RDY_LEAD && !rdy) begin
            cnt_q <= cnt_q;
          end else if (cnt_q == 5'd0) begin
            st_q  <= ST_REC;
            cnt_q <= rec_q - 5'd1;
          end else begin
            cnt_q <= cnt_q - 5'd1;
          end
        end
        ST_REC: begin
          if (cnt_q == 5'd0) begin
            st_q     <= ST_IDLE;
            CYC_DONE <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 5'd1;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  assign CMD_ACTIVE = (st_q == ST_CMD);
  assign CYC_BUSY   = (st_q != ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  chk_mask_decode: assert property (
    REGION2_HIT == (((CYC_ADDR[15:1] ^ REGION2_BASE[15:1]) & ~mask_q[15:1]) == 15'd0)
  ) else $error("region 2 decode wrong");
  chk_dma_fixed: assert property (
    start && CYC_IS_DMA |=> cnt_q == 5'd7 ##1 CMD_ACTIVE
  ) else $error("dma command not fixed");
  chk_ready_hold: assert property (
    CMD_ACTIVE && cnt_q == 5'd2 && !rdy |=> CMD_ACTIVE && cnt_q == 5'd2
  ) else $error("ready not honoured");
  chk_r0_wide_cmd: assert property (
    start && !CYC_IS_DMA && sel == REG_R0 && wide_d && tim_q[1:0] == 2'b00
    |=> cnt_q == 5'd7
  ) else $error("region 0 command length wrong");
  chk_r0_recovery: assert property (
    CMD_ACTIVE && cnt_q == 5'd0 && rec_q == 5'd10
    |=> st_q == ST_REC ##0 cnt_q == 5'd9 ##9 CYC_BUSY ##1 !CYC_BUSY && CYC_DONE
  ) else $error("recovery length wrong");
  chk_r1_narrow: assert property (
    start && !CYC_IS_DMA && sel == REG_R1 && !wide_d && tim_q[5:4] == 2'b01
    |=> cnt_q == 5'd15
  ) else $error("region 1 command length wrong");
  chk_r2_narrow: assert property (
    start && !CYC_IS_DMA && sel == REG_R2 && !wide_d && tim_q[9:8] == 2'b10
    |=> cnt_q == 5'd7
  ) else $error("region 2 command length wrong");
  chk_other_narrow: assert property (
    start && !CYC_IS_DMA && sel == REG_OTHER && !wide_d && tim_q[13:12] == 2'b11
    |=> cnt_q == 5'd3
  ) else $error("other command length wrong");
  chk_width_forced: assert property (
    start && wid_q[sel] |=> CYC_WIDE && CYC_REGION == $past(sel)
  ) else $error("forced width lost");
  chk_claim_other: assert property (
    start && sel == REG_OTHER && (io_claim || mem_claim) |=> CYC_WIDE
  ) else $error("claim not widening");
  chk_narrow_default: assert property (
    start && !wid_q[sel] && !io_claim && sel != REG_OTHER |=> !CYC_WIDE
  ) else $error("narrow default lost");
  chk_reserved_wide: assert property (
    start && !CYC_IS_DMA && wide_d && cmd_code == 2'b11 |=> cnt_q == 5'd3
  ) else $error("reserved wide code not shortest");

  cov_plain_cycle: cover property (start && !CYC_IS_DMA ##[1:60] CYC_DONE);
  cov_ready_stall: cover property (CMD_ACTIVE && cnt_q == 5'd2 && !rdy [*3]);
  cov_dma_cycle:   cover property (start && CYC_IS_DMA ##[1:20] CYC_DONE);
endmodule // exb_region_timing

// ### logic/exb_timing_lut.sv
module exb_timing_lut
  import exb_pkg::*;
(
  input  wire logic [1:0] cmd_code,
  input  wire logic [1:0] rec_code,
  input  wire logic       wide,
  output logic [4:0]      cmd_clks,
  output logic [4:0]      rec_clks
);
  always_comb begin
    case (cmd_code)
      2'b00:   cmd_clks = wide ? CMD16_C0 : CMD8_C0;
      2'b01:   cmd_clks = wide ? CMD16_C1 : CMD8_C1;
      2'b10:   cmd_clks = wide ? CMD16_C2 : CMD8_C2;
      // reserved wide code falls back to the shortest wide time
      default: cmd_clks = wide ? CMD16_C2 : CMD8_C3;
    endcase
    case (rec_code)
      2'b00:   rec_clks = REC_C0;
      2'b01:   rec_clks = REC_C1;
      2'b10:   rec_clks = REC_C2;
      default: rec_clks = REC_C3;
    endcase
  end
endmodule // exb_timing_lut

// ### tb/exb_periph_model.sv
module exb_periph_model (
  input  wire logic       clk,
  input  wire logic       cmd_active,
  input  wire logic       io_claim,
  input  wire logic       mem_claim,
  input  wire logic [4:0] stall_clks,
  output logic            ready,
  output logic            io_wide_claim_n,
  output logic            mem_wide_claim_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] wait_q = 5'h0;
  // not-ready held for stall_clks clocks once the command starts
  always @(posedge clk) begin
    if (!cmd_active) wait_q <= stall_clks;
    else if (wait_q != 5'h0) wait_q <= wait_q - 5'h1;
  end
  assign ready = (wait_q == 5'h0) || !cmd_active;
  // claim lines are pulled up, so released means high
  assign io_wide_claim_n  = !io_claim;
  assign mem_wide_claim_n = !mem_claim;
endmodule // exb_periph_model

// ### tb/exb_region_timing_tb.sv
module exb_region_timing_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import exb_pkg::*;
  logic clk = 0, rst = 1, wr = 0, rd = 0, start = 0, r0 = 0, r1 = 0, dma = 0;
  logic io_cl = 0, mem_cl = 0, busy, cmd, wide, done, r2hit, rdy, io_n, mem_n;
  logic [7:0] addr = 8'h00;
  logic [1:0] be = 2'b11;
  logic [15:0] wdata = 16'h0000, rdata, caddr = 16'h0000, base = 16'h0300;
  logic [4:0] stall = 5'h0;
  exb_region_t region;
  int miscompares = 0, total_checks = 0, cycles = 0;
  initial forever #50 clk = ~clk;
  exb_region_timing DUT (.REF_CLK(clk), .RESET(rst), .CFG_WR(wr), .CFG_RD(rd),
    .CFG_ADDR(addr), .CFG_BE(be), .CFG_WDATA(wdata), .CFG_RDATA(rdata),
    .CYC_START(start), .CYC_ADDR(caddr), .REGION2_BASE(base), .REGION0_HIT(r0),
    .REGION1_HIT(r1), .CYC_IS_DMA(dma), .IO_WIDE_CLAIM_N(io_n),
    .MEM_WIDE_CLAIM_N(mem_n), .EXPANSION_IO_READY(rdy), .REGION2_HIT(r2hit),
    .CYC_BUSY(busy), .CMD_ACTIVE(cmd), .CYC_WIDE(wide), .CYC_REGION(region),
    .CYC_DONE(done));
  exb_periph_model peer (.clk(clk), .cmd_active(cmd), .io_claim(io_cl),
    .mem_claim(mem_cl), .stall_clks(stall), .ready(rdy), .io_wide_claim_n(io_n),
    .mem_wide_claim_n(mem_n));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (miscompares == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // read data is valid one clock after the read edge
  task automatic cfg(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(negedge clk); wr = w; rd = !w; addr = a; wdata = d;
    @(negedge clk); wr = 0; rd = 0;
  endtask
  // sel 0..2 picks a region, 3 an unclaimed address
  task automatic run(input int sel, ecmd, erec, input logic ew, output int nc);
    int nr;
    nc = 0; nr = 0;
    @(negedge clk); r0 = (sel == 0); r1 = (sel == 1); start = 1;
    caddr = (sel == 2) ? 16'h0300 : 16'h0500;
    @(negedge clk); start = 0;
    repeat (100) begin
      if (done) break;
      if (cmd) nc++;
      else if (busy) nr++;
      @(negedge clk);
    end
    if (ecmd >= 0) chk(16'(nc), 16'(ecmd));
    chk(16'(nr), 16'(erec));
    chk({15'h0, wide}, {15'h0, ew});
    chk({14'h0, region}, 16'(sel));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    cfg(0, OFS_R2_MASK, 0); chk(rdata, RST_R2_MASK);
    cfg(0, OFS_TIMING, 0); chk(rdata, RST_TIMING);
    cfg(0, OFS_WIDTH, 0); chk(rdata, {12'h0, RST_WIDTH});
    cfg(1, OFS_R2_MASK, 16'hFFFF); cfg(0, OFS_R2_MASK, 0); chk(rdata, 16'hFFFE);
    cfg(1, OFS_WIDTH, 16'hFFFF); cfg(0, OFS_WIDTH, 0); chk(rdata, 16'h000F);
    cfg(1, 8'h7A, 16'hFFFF); cfg(0, 8'h7A, 0); chk(rdata, 16'h0000);
    be = 2'b01; cfg(1, OFS_TIMING, 16'hABCD); be = 2'b11;
    cfg(0, OFS_TIMING, 0); chk(rdata, 16'h00CD);
    cfg(1, OFS_R2_MASK, 0);
  endtask
  // each region gets its own codes so a misrouted field shows
  task automatic t_codes();
    int c16[4] = '{8, 6, 4, 4};
    int c8[4] = '{20, 16, 8, 4};
    int rc[4] = '{10, 8, 6, 4};
    int nc;
    logic [15:0] t;
    for (int w = 0; w < 2; w++) begin
      for (int c = 0; c < 4; c++) begin
        for (int s = 0; s < 4; s++) t[4*s +: 4] = {2'((c + s + 1) % 4), 2'((c + s) % 4)};
        cfg(1, OFS_TIMING, t); cfg(1, OFS_WIDTH, {12'h0, {4{w[0]}}});
        for (int s = 0; s < 4; s++) begin
          run(s, w ? c16[(c+s)%4] : c8[(c+s)%4], rc[(c+s+1)%4], w[0], nc);
        end
      end
    end
  endtask
  task automatic t_mask();
    logic [15:0] mk[4] = '{16'h00FE, 16'h00FE, 16'h0000, 16'h0000};
    logic [15:0] ad[4] = '{16'h03FF, 16'h0700, 16'h0301, 16'h0302};
    for (int i = 0; i < 4; i++) begin
      cfg(1, OFS_R2_MASK, mk[i]); caddr = ad[i]; #1;
      chk({15'h0, r2hit}, {15'h0, i[0] == 0});
    end
    cfg(1, OFS_R2_MASK, 0);
  endtask
  task automatic t_misc();
    int nc;
    cfg(1, OFS_TIMING, 16'h0000); cfg(1, OFS_WIDTH, 16'h0000);
    io_cl = 1; repeat (3) @(negedge clk);
    run(0, 8, 10, 1, nc); run(2, 8, 10, 1, nc);
    io_cl = 0; mem_cl = 1; repeat (3) @(negedge clk);
    run(1, 20, 10, 0, nc); run(3, 8, 10, 1, nc);
    // stall must outlast the sample point plus the two-stage pin delay
    mem_cl = 0; stall = 5'd24; repeat (3) @(negedge clk);
    run(0, -1, 10, 0, nc); chk(16'(nc > 20), 16'h0001);
    // programmed 16/8 shape differs from the fixed 8/4 one
    stall = 5'h0; cfg(1, OFS_TIMING, 16'h5555); dma = 1;
    run(0, 8, 4, 0, nc); dma = 0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // a hang ends the run well after all cycles should be finished
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    repeat (20) @(negedge clk);
    rst = 0;
    t_regs();
    t_mask();
    t_codes();
    t_misc();
    conclude();
  end
endmodule // exb_region_timing_tb
